// [maf_filter.sv]
// Moving-average power filter: circular window with running sum and
// a reading republished every 50 ms.
// Assumes samples come from logic on this clock; the trigger is a pin.
`include "maf_defines.svh"

module maf_filter #(
    parameter int TICK_CYC = `MAF_TICK_CYC
) (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    input  wire maf_pkg::maf_cfg_t        cfg,
    input  wire logic                     trigger_pin,
    input  wire logic [`MAF_SAMPLE_W-1:0] sample_data,
    input  wire logic                     sample_valid,
    output logic                          sample_ready,
    output maf_pkg::maf_rdg_t             reading
);
    localparam int NS = `MAF_MAX_SAMPLES;
    localparam logic [`MAF_CNT_W-1:0] LEN_MIN = `MAF_CNT_W'(`MAF_MIN_SAMPLES);
    localparam logic [`MAF_CNT_W-1:0] LEN_MAX = `MAF_CNT_W'(NS);
    localparam logic [`MAF_CNT_W-1:0] LEN_D0  = `MAF_CNT_W'(`MAF_DEF0_SAMPLES);
    localparam logic [`MAF_CNT_W-1:0] LEN_D   = `MAF_CNT_W'(`MAF_DEF_SAMPLES);
    localparam logic [`MAF_TICK_W-1:0] TICK_LAST = `MAF_TICK_W'(TICK_CYC - 1);
    localparam int SW = `MAF_SAMPLE_W;
    localparam int CW = `MAF_CNT_W;
    // Local names for the sequencer states, taken from the package.
    localparam maf_pkg::maf_state_t ST_IDLE     = maf_pkg::ST_IDLE;
    localparam maf_pkg::maf_state_t ST_UPDATE   = maf_pkg::ST_UPDATE;
    localparam maf_pkg::maf_state_t ST_DIVSTART = maf_pkg::ST_DIVSTART;
    localparam maf_pkg::maf_state_t ST_DIVWAIT  = maf_pkg::ST_DIVWAIT;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [SW-1:0]  win_mem [NS];
    maf_pkg::maf_state_t st_reg, st_next;
    logic [`MAF_SUM_W-1:0] sum_reg, sum_next;
    logic [CW-1:0]  cnt_reg, cnt_next, len_reg, len_next, len_sel;
    logic [CW-1:0]  wr_reg, wr_next, old_idx;
    logic [SW-1:0]  avg_reg, avg_next, fifo_data, div_quo, diff;
    logic           have_reg, have_next, pend_reg, pend_next;
    logic           trig_s1_reg, trig_s2_reg, trig_d_reg, trig_rise;
    logic [`MAF_TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic           tick;
    maf_pkg::maf_rdg_t rdg_reg, rdg_next;
    logic           fifo_valid, fifo_pop, clr_ack, len_chg, trip, full;
    logic           mem_we, div_done;
    logic [SW-1:0]  mem_wdata;
    logic [CW-1:0]  mem_addr;
    logic [SW+15:0] lhs, rhs;

    // ------------------------------------------------------------------------
    // Sample buffering
    // ------------------------------------------------------------------------
    maf_fifo #(
        .WIDTH (SW),
        .DEPTH (`MAF_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------------------
    // Trigger synchroniser and cadence timer
    // ------------------------------------------------------------------------
    // The trigger comes from a pin; the edge is taken from the second stage and its delayed copy.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_d_reg  <= 1'b0;
        end else begin
            trig_s1_reg <= trigger_pin;
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg  <= trig_s2_reg;
        end
    end

    assign trig_rise = trig_s2_reg && !trig_d_reg;

    always_comb begin
        tick          = (tick_cnt_reg == TICK_LAST);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    end

    // ------------------------------------------------------------------------
    // Filter length selection
    // ------------------------------------------------------------------------
    always_comb begin
        if (cfg.use_default) begin
            len_sel = (cfg.range == `MAF_LOW_RANGE) ? LEN_D0 : LEN_D;
        end else if (cfg.filt_len < LEN_MIN) begin
            len_sel = LEN_MIN;
        end else if (cfg.filt_len > LEN_MAX) begin
            len_sel = LEN_MAX;
        end else begin
            len_sel = cfg.filt_len;
        end
    end

    // ------------------------------------------------------------------------
    // Window arithmetic helpers
    // ------------------------------------------------------------------------
    always_comb begin
        full    = (cnt_reg >= len_reg);
        old_idx = (wr_reg >= len_reg) ? wr_reg - len_reg
                                      : CW'(wr_reg + LEN_MAX - len_reg);
        diff    = (fifo_data > avg_reg) ? fifo_data - avg_reg
                                        : avg_reg - fifo_data;
        lhs     = {diff, 16'h0000};
        rhs     = (SW+16)'(avg_reg * `MAF_AUTO_THR_Q16);
        // Auto clear on 0.02 dB change.
        trip    = cfg.auto_en && have_reg && (lhs > rhs);
    end

    // ------------------------------------------------------------------------
    // Sequencer: clear, insert sample, divide
    // ------------------------------------------------------------------------
    // A clear is taken only between samples, so sum and buffer never
    // disagree; a request during a division waits about 35 cycles.
    always_comb begin
        st_next   = st_reg;
        sum_next  = sum_reg;
        cnt_next  = cnt_reg;
        wr_next   = wr_reg;
        len_next  = len_reg;
        avg_next  = avg_reg;
        have_next = have_reg;
        fifo_pop  = 1'b0;
        clr_ack   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = wr_reg;
        mem_wdata = fifo_data;
        case (st_reg)
            ST_IDLE: begin
                if (pend_reg) begin
                    clr_ack   = 1'b1;
                    sum_next  = '0;
                    cnt_next  = '0;
                    wr_next   = '0;
                    have_next = 1'b0;
                    len_next  = len_sel;
                end else if (fifo_valid) begin
                    st_next = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                fifo_pop = 1'b1;
                mem_we   = 1'b1;
                if (trip) begin
                    // Restart from empty with this sample as the first.
                    mem_addr = '0;
                    sum_next = `MAF_SUM_W'(fifo_data);
                    cnt_next = CW'(1);
                    wr_next  = CW'(1);
                end else if (full) begin
                    // Constant-step swap gives a linear ramp.
                    sum_next = sum_reg + `MAF_SUM_W'(fifo_data)
                             - `MAF_SUM_W'(win_mem[old_idx]);
                    wr_next  = (wr_reg == LEN_MAX - 1'b1) ? '0 : wr_reg + 1'b1;
                end else begin
                    sum_next = sum_reg + `MAF_SUM_W'(fifo_data);
                    cnt_next = cnt_reg + 1'b1;
                    wr_next  = (wr_reg == LEN_MAX - 1'b1) ? '0 : wr_reg + 1'b1;
                end
                st_next = ST_DIVSTART;
            end
            ST_DIVSTART: begin
                st_next = ST_DIVWAIT;
            end
            ST_DIVWAIT: begin
                if (div_done) begin
                    avg_next  = div_quo;
                    have_next = 1'b1;
                    st_next   = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    maf_divider u_div (
        .clock    (clock),
        .arst_n   (arst_n),
        .start    (st_reg == ST_DIVSTART),
        .dividend (sum_reg),
        .divisor  (cnt_reg),
        .quotient (div_quo),
        .done     (div_done)
    );

    // ------------------------------------------------------------------------
    // Clear requests and publication
    // ------------------------------------------------------------------------
    always_comb begin
        len_chg   = (len_sel != len_reg) && !clr_ack;
        // Trigger clears window when enabled. A trigger in the ack cycle wins over the ack.
        pend_next = len_chg || (trig_rise && cfg.trig_clear_en)
                 || (pend_reg && !clr_ack);
        rdg_next       = rdg_reg;
        rdg_next.valid = 1'b0;
        rdg_next.count = cnt_reg;
        if (tick && have_reg && !(cfg.settled_en && !full)) begin
            rdg_next.value   = avg_reg;
            rdg_next.valid   = 1'b1;
            rdg_next.partial = !full;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg       <= maf_pkg::ST_IDLE;
            sum_reg      <= '0;
            cnt_reg      <= '0;
            wr_reg       <= '0;
            len_reg      <= LEN_MIN;
            avg_reg      <= '0;
            have_reg     <= 1'b0;
            pend_reg     <= 1'b1; // Load the configured length first.
            tick_cnt_reg <= '0;
            rdg_reg      <= '0;
        end else begin
            st_reg       <= st_next;
            sum_reg      <= sum_next;
            cnt_reg      <= cnt_next;
            wr_reg       <= wr_next;
            len_reg      <= len_next;
            avg_reg      <= avg_next;
            have_reg     <= have_next;
            pend_reg     <= pend_next;
            tick_cnt_reg <= tick_cnt_next;
            rdg_reg      <= rdg_next;
        end
    end

    // Window storage; written once per accepted sample.
    always_ff @(posedge clock) begin
        if (mem_we) begin
            win_mem[mem_addr] <= mem_wdata;
        end
    end

    assign reading = rdg_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_RDG_IS_AVG: assert property (
        rdg_reg.valid |-> rdg_reg.value == $past(avg_reg))
        else $error("Reading differs from window mean.");
    AST_TICK_CADENCE: assert property (
        rdg_reg.valid |-> $past(tick) && !$past(rdg_reg.valid))
        else $error("Reading strobe off the 50 ms cadence.");
    AST_LEN_RANGE: assert property (
        len_reg >= LEN_MIN && len_reg <= LEN_MAX)
        else $error("Filter length outside legal span.");
    AST_LEN_ONE: assert property (
        st_reg == ST_UPDATE && len_reg == LEN_MIN && !trip && full
        |=> sum_reg == `MAF_SUM_W'($past(fifo_data)))
        else $error("Single-sample window is not the latest sample.");
    AST_AUTO_CLEAR: assert property (
        st_reg == ST_UPDATE && trip |=> cnt_reg == CW'(1))
        else $error("Auto clear did not restart the window.");
    AST_CLEAR_SERVED: assert property (
        pend_reg |-> ##[0:60] clr_ack)
        else $error("Pending clear not served in time.");
    AST_TRIG_CLEAR: assert property (
        trig_rise && cfg.trig_clear_en |=> pend_reg)
        else $error("Trigger did not request a clear.");
    AST_DIV_BY_CNT: assert property (
        div_done |-> (`MAF_SUM_W'(div_quo * cnt_reg) <= sum_reg)
        && (sum_reg - `MAF_SUM_W'(div_quo * cnt_reg) < `MAF_SUM_W'(cnt_reg)))
        else $error("Mean not divided by held count.");
    AST_SLIDE_KEEPS_CNT: assert property (
        st_reg == ST_UPDATE && full && !trip |=> $stable(cnt_reg))
        else $error("Full window changed its sample count.");
    AST_SETTLED_HOLD: assert property (
        rdg_reg.valid && $past(cfg.settled_en) |-> !rdg_reg.partial)
        else $error("Settled mode published a partial reading.");
    AST_CLEAR_EMPTY: assert property (
        clr_ack |=> cnt_reg == '0 && sum_reg == '0 && !have_reg)
        else $error("Clear left samples in the window.");

    COV_PARTIAL: cover property (rdg_reg.valid && rdg_reg.partial);
    COV_FULL: cover property (rdg_reg.valid && !rdg_reg.partial);
    COV_AUTO_TRIP: cover property (st_reg == ST_UPDATE && trip);
    COV_TRIG: cover property (trig_rise && cfg.trig_clear_en);

endmodule : maf_filter

// [maf_defines.svh]
// Constants for the moving-average power filter: timing, sizes, thresholds.
// Assumes inclusion by the package and by every design file that needs them.
`ifndef MAF_DEFINES_SVH
`define MAF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MAF_CLK_HZ        40000000
`define MAF_SAMPLE_MS     50
`define MAF_TICK_CYC      ((`MAF_CLK_HZ / 1000) * `MAF_SAMPLE_MS)
`define MAF_TICK_W        22

// ----------------------------------------------------------------------------
// Filter lengths
// ----------------------------------------------------------------------------
`define MAF_MIN_LEN_MS    50
`define MAF_MAX_LEN_MS    20000
`define MAF_MIN_SAMPLES   (`MAF_MIN_LEN_MS / `MAF_SAMPLE_MS)
`define MAF_MAX_SAMPLES   (`MAF_MAX_LEN_MS / `MAF_SAMPLE_MS)
`define MAF_DEF0_LEN_MS   2800
`define MAF_DEF_LEN_MS    800
`define MAF_DEF0_SAMPLES  (`MAF_DEF0_LEN_MS / `MAF_SAMPLE_MS)
`define MAF_DEF_SAMPLES   (`MAF_DEF_LEN_MS / `MAF_SAMPLE_MS)
`define MAF_LOW_RANGE     3'h0

// ----------------------------------------------------------------------------
// Widths and thresholds
// ----------------------------------------------------------------------------
`define MAF_SAMPLE_W      24
`define MAF_CNT_W         9
`define MAF_SUM_W         33
`define MAF_FIFO_DEPTH    8
// Relative step of 0.02 dB is about 0.4616 percent, scaled by 2^16.
`define MAF_AUTO_THR_Q16  16'h012f

`endif

// [maf_pkg.sv]
// Types shared by the moving-average power filter modules.
// Assumes maf_defines.svh is on the include path.
`include "maf_defines.svh"

package maf_pkg;

    // Control state of the filter sequencer.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_UPDATE,
        ST_DIVSTART,
        ST_DIVWAIT
    } maf_state_t;

    // Configuration bits supplied by the control logic.
    typedef struct packed {
        logic [`MAF_CNT_W-1:0] filt_len;      // Length in 50 ms samples.
        logic                  use_default;   // Range-dependent length.
        logic [2:0]            range;         // Present measurement range.
        logic                  auto_en;       // Clear on 0.02 dB change.
        logic                  trig_clear_en; // Clear on trigger.
        logic                  settled_en;    // Hold off until settled.
    } maf_cfg_t;

    // Published reading.
    typedef struct packed {
        logic [`MAF_SAMPLE_W-1:0] value;
        logic                     valid;      // One-cycle strobe.
        logic                     partial;    // Window not yet full.
        logic [`MAF_CNT_W-1:0]    count;      // Samples held.
    } maf_rdg_t;

endpackage : maf_pkg

// [maf_fifo.sv]
// Sample FIFO with valid/ready on both sides and registered flags.
// Assumes both sides run on the one clock of the filter.
`include "maf_defines.svh"

module maf_fifo #(
    parameter int WIDTH = `MAF_SAMPLE_W,
    parameter int DEPTH = `MAF_FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             full_reg, full_next, empty_reg, empty_next;
    logic             rdy_reg, rdy_next;
    logic             push, pop;

    // ------------------------------------------------------------------------
    // Pointer and flag update
    // ------------------------------------------------------------------------
    // Flags are registered so that ready leaves this block from a flop.
    always_comb begin
        push       = in_valid && !full_reg;
        pop        = out_ready && !empty_reg;
        wr_next    = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next    = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next   = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        full_next  = (cnt_next == FULL_CNT);
        empty_next = (cnt_next == '0);
        rdy_next   = !full_next;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            full_reg  <= 1'b0;
            rdy_reg   <= 1'b1;
            empty_reg <= 1'b1;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            cnt_reg   <= cnt_next;
            full_reg  <= full_next;
            rdy_reg   <= rdy_next;
            empty_reg <= empty_next;
        end
    end

    // Storage has no reset; contents are only read behind a valid.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready  = rdy_reg;
    assign out_valid = !empty_reg;
    assign out_data  = mem[rd_reg];

endmodule : maf_fifo

// [maf_divider.sv]
// Sequential restoring divider: window sum over the number of samples held.
// Assumes start only while idle and a non-zero divisor.
`include "maf_defines.svh"

module maf_divider (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    input  wire logic                     start,
    input  wire logic [`MAF_SUM_W-1:0]    dividend,
    input  wire logic [`MAF_CNT_W-1:0]    divisor,
    output logic      [`MAF_SAMPLE_W-1:0] quotient,
    output logic                          done
);
    logic [`MAF_SUM_W-1:0] quo_reg, quo_next;
    logic [`MAF_CNT_W:0]   rem_reg, rem_next, trial;
    logic [`MAF_CNT_W-1:0] dsr_reg, dsr_next;
    logic [5:0]            step_reg, step_next;
    logic                  done_reg, done_next;

    // ------------------------------------------------------------------------
    // One quotient bit per cycle
    // ------------------------------------------------------------------------
    // Bit-serial trades 33 cycles of latency for a tiny area; the 50 ms
    // sample spacing leaves ample time.
    always_comb begin
        quo_next  = quo_reg;
        rem_next  = rem_reg;
        dsr_next  = dsr_reg;
        step_next = step_reg;
        done_next = 1'b0;
        trial     = {rem_reg[`MAF_CNT_W-1:0], quo_reg[`MAF_SUM_W-1]};
        if (start) begin
            quo_next  = dividend;
            rem_next  = '0;
            dsr_next  = divisor;
            step_next = 6'(`MAF_SUM_W);
        end else if (step_reg != 6'h00) begin
            quo_next  = {quo_reg[`MAF_SUM_W-2:0], 1'b0};
            rem_next  = trial;
            if (trial >= {1'b0, dsr_reg}) begin
                rem_next    = trial - {1'b0, dsr_reg};
                quo_next[0] = 1'b1;
            end
            step_next = step_reg - 6'h01;
            done_next = (step_reg == 6'h01);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            quo_reg  <= '0;
            rem_reg  <= '0;
            dsr_reg  <= '0;
            step_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            quo_reg  <= quo_next;
            rem_reg  <= rem_next;
            dsr_reg  <= dsr_next;
            step_reg <= step_next;
            done_reg <= done_next;
        end
    end

    // The mean never exceeds the largest sample, so the top bits are zero.
    assign quotient = quo_reg[`MAF_SAMPLE_W-1:0];
    assign done     = done_reg;

endmodule : maf_divider

// [maf_src_model.sv]
// Sample source standing in for the measurement front end.
// Assumes the filter's one clock; valid is held until ready is seen.
// ----------------------------------------------------------------------
// Source model
// ----------------------------------------------------------------------
module maf_src_model (
    input  wire logic        clock,
    input  wire logic        sample_ready,
    output logic      [23:0] sample_data,
    output logic             sample_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sample_valid = 1'b0;
        sample_data  = 24'h000000;
    end
    // Offer one word and hold it until ready is sampled high.
    // After release the data shows the inverse, never a stale value.
    task put(input logic [23:0] d);
        @(posedge clock);
        sample_valid <= 1'b1;
        sample_data  <= d;
        do @(posedge clock); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
        sample_data  <= ~d;
    endtask : put
endmodule : maf_src_model

// [maf_filter_test.sv]
// Self-checking bench for the moving-average filter.
// Assumes a short tick so that each published reading comes quickly.
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module maf_filter_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 200;
    logic                  clock = 1'b0;
    logic                  arst_n = 1'b0;
    logic                  trigger_pin = 1'b0;
    maf_pkg::maf_cfg_t     cfg = 16'h0080; // Length one, no options.
    logic [23:0]           sample_data;
    logic                  sample_valid;
    logic                  sample_ready;
    maf_pkg::maf_rdg_t     reading;
    int                    miscompares = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;
    int                    t0;
    maf_filter #(.TICK_CYC(TICK)) u_maf_filter (.clock(clock),
        .arst_n(arst_n), .cfg(cfg), .trigger_pin(trigger_pin),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .reading(reading));
    maf_src_model u_maf_src_model (.clock(clock),
        .sample_ready(sample_ready), .sample_data(sample_data),
        .sample_valid(sample_valid));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // A hung run is cut short; the ceiling is far above the test length.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    task chk(input logic [23:0] s, input logic [23:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Wait for the next published reading, looked at mid-cycle.
    task rd();
        int n;
        n = 0;
        @(negedge clock);
        while (reading.valid !== 1'b1 && n < 1000) begin
            n++;
            @(negedge clock);
        end
        chk({23'h0, reading.valid}, 24'h1);
    endtask : rd
    // No reading may appear during a full tick.
    task quiet();
        logic seen;
        seen = 1'b0;
        repeat (TICK + 10) @(negedge clock) seen |= (reading.valid === 1'b1);
        chk({23'h0, seen}, 24'h0);
    endtask : quiet
    task put_rd(input logic [23:0] d, input logic [23:0] e);
        u_maf_src_model.put(d);
        rd();
        chk(reading.value, e);
    endtask : put_rd
    // Queue n equal samples, then leave time to digest the backlog.
    // Nine or more in a row outrun the drain, so the queue ends full.
    task fill(input int n);
        repeat (n) u_maf_src_model.put(24'h000010);
        @(negedge clock);
        chk({23'h0, sample_ready}, (n > 8) ? 24'h0 : 24'h1);
        repeat (400) @(posedge clock);
    endtask : fill
    task summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        put_rd(24'h000100, 24'h000100);
        chk({23'h0, reading.partial}, 24'h0);
        put_rd(24'h000200, 24'h000200);
        @(posedge clock);
        cfg.filt_len <= 9'h004;
        repeat (50) @(posedge clock);
        chk({15'h0, reading.count}, 24'h0);
        put_rd(24'h00000a, 24'h00000a);
        chk({23'h0, reading.partial}, 24'h1);
        u_maf_src_model.put(24'h000014);
        put_rd(24'h00001e, 24'h000014);
        put_rd(24'h000028, 24'h000019);
        put_rd(24'h000032, 24'h000023);
        put_rd(24'h000032, 24'h00002a);
        @(posedge clock);
        cfg.trig_clear_en <= 1'b1;
        trigger_pin <= 1'b1;
        repeat (5) @(posedge clock);
        trigger_pin <= 1'b0;
        repeat (50) @(posedge clock);
        chk({15'h0, reading.count}, 24'h0);
        cfg.settled_en <= 1'b1;
        u_maf_src_model.put(24'h000005);
        quiet();
        u_maf_src_model.put(24'h000006);
        u_maf_src_model.put(24'h000007);
        put_rd(24'h000008, 24'h000006);
        t0 = cyc;
        rd();
        chk(24'(cyc - t0), 24'(TICK));
        @(posedge clock);
        cfg.settled_en <= 1'b0;
        cfg.auto_en <= 1'b1;
        put_rd(24'h001000, 24'h001000);
        chk({15'h0, reading.count}, 24'h1);
        // Default length on range 1: sixteen samples fill the window.
        @(posedge clock);
        cfg <= 16'h0248;
        repeat (20) @(posedge clock);
        chk({15'h0, reading.count}, 24'h0);
        fill(15);
        rd();
        chk(reading.value, 24'h000010);
        chk({15'h0, reading.count}, 24'h00000f);
        chk({23'h0, reading.partial}, 24'h1);
        fill(1);
        rd();
        chk({15'h0, reading.count}, 24'h000010);
        chk({23'h0, reading.partial}, 24'h0);
        // Default length on range 0 is longer: still partial at 17.
        @(posedge clock);
        cfg <= 16'h0240;
        repeat (20) @(posedge clock);
        chk({15'h0, reading.count}, 24'h0);
        fill(17);
        rd();
        chk({15'h0, reading.count}, 24'h000011);
        chk({23'h0, reading.partial}, 24'h1);
        summarize();
    end
endmodule : maf_filter_test
